// ==== shared/sfda_pkg.sv ====
// constants and types shared by the flash digital access block
package sfda_pkg;
   // opcodes
   localparam logic [7:0] SFDA_OP_READ = 8'hA2;
   localparam logic [7:0] SFDA_OP_WRITE = 8'hA0;
   localparam logic [7:0] SFDA_OP_ERASE = 8'h24;
   // framing
   localparam int SFDA_ADDR_W = 24;
   localparam logic [1:0] SFDA_ADDR_FIRST = 2'h0;
   localparam logic [1:0] SFDA_ADDR_LAST = 2'h2;
   localparam logic [2:0] SFDA_BIT_FIRST = 3'h0;
   localparam logic [2:0] SFDA_BIT_LAST = 3'h7;
   localparam logic [2:0] SFDA_BIT_STEP = 3'h1;
   // array geometry
   localparam int SFDA_SECTOR_AW = 10;
   localparam logic [SFDA_SECTOR_AW-1:0] SFDA_SECTOR_LAST = 10'h3FF;
   localparam logic [SFDA_SECTOR_AW-1:0] SFDA_SECTOR_STEP = 10'h001;
   localparam int SFDA_MEM_AW_DEF = 16;
   localparam logic [SFDA_ADDR_W-1:0] SFDA_ADDR_STEP = 24'h000001;
   localparam logic [SFDA_ADDR_W-1:0] SFDA_ADDR_ZERO = 24'h000000;
   localparam logic [7:0] SFDA_ERASED = 8'hFF;
   localparam logic [7:0] SFDA_ZERO = 8'h00;
   // timing
   localparam int SFDA_CLK_PERIOD_NS = 20;
   localparam int SFDA_NS_PER_US = 1000;
   localparam int SFDA_PROG_TIME_US = 20;
   localparam int SFDA_PROG_CW = 16;
   localparam logic [SFDA_PROG_CW-1:0] SFDA_PROG_ZERO = 16'h0000;
   localparam logic [SFDA_PROG_CW-1:0] SFDA_PROG_STEP = 16'h0001;
   // synchroniser reset: sclk low, mosi low, select released
   localparam logic [2:0] SFDA_PINS_RST = 3'h1;

   typedef enum {PH_IDLE, PH_OPC, PH_ADDR, PH_READ, PH_WRITE, PH_SKIP} sfda_phase_e;
   typedef enum {ENG_IDLE, ENG_ERASE, ENG_PROG} sfda_eng_e;

   typedef struct packed {
      logic rsv7;
      logic dbuf_ready;
      logic rsv5;
      logic rsv4;
      logic channel_busy;
      logic digital_busy;
      logic powered_down;
      logic command_busy;
   } sfda_status_s;

   typedef struct packed {
      logic we;
      logic re;
      logic [SFDA_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } sfda_mem_req_s;
endpackage : sfda_pkg

// ==== verification/sfda_host.sv ====
// serial host model, mode 0, link clock still outside frames
`timescale 1ns/1ps
`default_nettype none
module sfda_host (
   input wire logic miso,
   input wire logic ready_busy_n,
   output logic sclk,
   output logic mosi,
   output logic ss_n
);
   initial begin
      sclk = 1'h0;
      mosi = 1'h0;
      ss_n = 1'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic open_frame();
      ss_n = 1'h0;
      #160;
   endtask : open_frame
   task automatic close_frame();
      #80;
      ss_n = 1'h1;
      // released data line flips so a stale bit is never read as valid
      mosi = ~mosi;
      #160;
   endtask : close_frame
   task automatic xfer(input logic [7:0] tx, input logic chk, output logic [7:0] rx);
      #160;
      // wait for ready before every byte when chk is set
      for (int n = 0; n < 4000 && chk && ready_busy_n !== 1'h1; n++) #20;
      for (int n = 7; n >= 0; n--) begin
         mosi = tx[n];
         #80 sclk = 1'h1;
         rx[n] = miso;
         #80 sclk = 1'h0;
      end
   endtask : xfer
endmodule : sfda_host
`default_nettype wire

// ==== verification/sfda_properties.sv ====
// concurrent checks on the ports of the flash access block
`timescale 1ns/1ps
`default_nettype none
module sfda_properties import sfda_pkg::*; #(
   parameter int PROG_TIME_US = SFDA_PROG_TIME_US
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic slave_select_n,
   input wire logic ready_busy_n,
   input wire logic powered_down_flag,
   input wire logic data_buffer_ready_flag,
   input wire logic channel_busy_flag,
   input wire logic digital_busy_flag,
   input wire logic command_busy_flag,
   input wire logic flash_read_cmd,
   input wire logic flash_write_cmd,
   input wire logic program_done_irq,
   input wire logic command_done_irq,
   input wire logic command_reject_irq
);
   localparam int PROG_CYC = (PROG_TIME_US * SFDA_NS_PER_US + SFDA_CLK_PERIOD_NS - 1) / SFDA_CLK_PERIOD_NS;
   logic unready;
   // any erase blocker, so the reject pulse can be traced back one cycle
   assign unready = powered_down_flag | ~data_buffer_ready_flag | channel_busy_flag | digital_busy_flag
      | command_busy_flag;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   AST_PROG_EDGE: assert property (program_done_irq |-> $fell(command_busy_flag))
      else $error("program done not at busy fall");
   AST_PROG_LEN: assert property (program_done_irq |-> $past(command_busy_flag, PROG_CYC))
      else $error("program busy too short");
   AST_ERASE_EDGE: assert property (command_done_irq |-> $fell(command_busy_flag))
      else $error("command done not at busy fall");
   AST_ERASE_LEN: assert property (command_done_irq |-> $past(command_busy_flag, 300))
      else $error("erase busy too short");
   AST_BUSY_HOLD: assert property (command_busy_flag [*3] |-> !ready_busy_n)
      else $error("ready high while busy");
   AST_REJECT: assert property (command_reject_irq |-> $past(unready))
      else $error("erase rejected while idle");
   AST_SEL_OE: assert property (!slave_select_n [*6] |-> spi_miso_oe)
      else $error("miso not driven while selected");
   AST_DESEL: assert property (slave_select_n [*6] |-> !(spi_miso_oe | spi_miso | flash_read_cmd | flash_write_cmd))
      else $error("activity while deselected");
endmodule : sfda_properties
bind sfda_top sfda_properties #(.PROG_TIME_US(PROG_TIME_US)) u_props (.clk, .rst, .spi_miso, .spi_miso_oe,
   .slave_select_n, .ready_busy_n, .powered_down_flag, .data_buffer_ready_flag, .channel_busy_flag,
   .digital_busy_flag, .command_busy_flag, .flash_read_cmd, .flash_write_cmd, .program_done_irq,
   .command_done_irq, .command_reject_irq);
`default_nettype wire

// ==== verification/spi_flash_digital_access_bench.sv ====
// self-checking bench for the flash digital access block
`timescale 1ns/1ps
`default_nettype none
module spi_flash_digital_access_bench import sfda_pkg::*; ();
   localparam logic [4:0] I_NO = 5'h00;
   localparam logic [4:0] I_REJ = 5'h01;
   localparam logic [4:0] I_CMD = 5'h02;
   localparam logic [4:0] I_PRG = 5'h04;
   localparam logic [4:0] I_OV = 5'h08;
   localparam logic [4:0] I_AF = 5'h10;
   logic clk, rst, sclk, mosi, ss_n, miso, oe, ready, busy, line, last_bit, clr, wait_rdy;
   logic pwr_dn, buf_ok, chan_busy, dig_busy;
   logic [23:0] rpl, wpl;
   logic [4:0] irq, seen;
   int miscompares, num_checks, cyc;
   // undriven miso shows the inverse of its last bit
   assign line = oe ? miso : ~last_bit;
   sfda_top #(.PROG_TIME_US(1)) dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_mosi(mosi), .slave_select_n(ss_n),
      .spi_miso(miso), .spi_miso_oe(oe), .ready_busy_n(ready), .powered_down_flag(pwr_dn),
      .data_buffer_ready_flag(buf_ok), .channel_busy_flag(chan_busy), .digital_busy_flag(dig_busy),
      .read_protect_limit(rpl), .write_protect_limit(wpl), .command_busy_flag(busy), .flash_read_cmd(),
      .flash_write_cmd(), .address_fault_irq(irq[4]), .overflow_fault_irq(irq[3]), .program_done_irq(irq[2]),
      .command_done_irq(irq[1]), .command_reject_irq(irq[0]));
   sfda_host host (.miso(line), .ready_busy_n(ready), .sclk(sclk), .mosi(mosi), .ss_n(ss_n));
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (oe) last_bit <= miso;
      seen <= clr ? I_NO : (seen | irq);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [7:0] stat(input logic b);
      return {1'h0, buf_ok, 2'h0, chan_busy, dig_busy, pwr_dn, b};
   endfunction : stat
   task automatic xb(input logic [7:0] t, input logic [7:0] x);
      logic [7:0] r;
      host.xfer(t, wait_rdy, r);
      chk("miso", x, r);
   endtask : xb
   // second data byte is the inverse of the first
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input logic [7:0] s0, input logic [7:0] s,
      input int n, input logic [7:0] d);
      host.open_frame();
      xb(op, s0);
      for (int i = 2; i >= 0; i--) xb(a[8*i+:8], s);
      for (int i = 0; i < n; i++) xb(i ? ~d : d, (op == SFDA_OP_WRITE) ? s : (i ? ~d : d));
      host.close_frame();
   endtask : frame
   task automatic post(input logic b, input logic w, input logic [4:0] x);
      chk("busy", {7'h00, b}, {7'h00, busy});
      for (int n = 0; n < 3000 && w && busy !== 1'h0; n++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("irq", {3'h0, x}, {3'h0, seen});
      clr = 1'h1;
      @(negedge clk);
      clr = 1'h0;
   endtask : post
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   initial begin
      rst = 1'h1;
      clr = 1'h1;
      wait_rdy = 1'h1;
      {pwr_dn, buf_ok, chan_busy, dig_busy} = 4'h4;
      rpl = 24'h000000;
      wpl = 24'h000000;
      last_bit = 1'h0;
      cyc = 0;
      miscompares = 0;
      num_checks = 0;
      repeat (20) @(negedge clk);
      rst = 1'h0;
      repeat (4) @(negedge clk);
      clr = 1'h0;
      frame(SFDA_OP_WRITE, 24'h000400, 8'h40, 8'h40, 2, 8'hAA);
      post(1'h1, 1'h1, I_PRG);
      frame(SFDA_OP_READ, 24'h000400, 8'h40, 8'h40, 2, 8'hAA);
      post(1'h0, 1'h0, I_NO);
      for (int i = 0; i < 4; i++) begin
         {pwr_dn, buf_ok, chan_busy, dig_busy} = 4'h4 ^ (4'h1 << i);
         frame(SFDA_OP_ERASE, 24'h000500, stat(1'h0), stat(1'h0), 0, 8'h00);
         post(1'h0, 1'h0, I_REJ);
      end
      {pwr_dn, buf_ok, chan_busy, dig_busy} = 4'h4;
      frame(SFDA_OP_ERASE, 24'h000500, 8'h40, 8'h40, 0, 8'h00);
      post(1'h1, 1'h0, I_NO);
      wait_rdy = 1'h0;
      frame(SFDA_OP_READ, 24'h000400, 8'h41, 8'h41, 1, 8'h00);
      post(1'h1, 1'h0, I_OV);
      frame(SFDA_OP_WRITE, 24'h000400, 8'h41, 8'h41, 1, 8'h33);
      post(1'h1, 1'h0, I_OV);
      wait_rdy = 1'h1;
      frame(SFDA_OP_READ, 24'h000400, 8'h41, 8'h40, 1, 8'hFF);
      post(1'h0, 1'h0, I_CMD);
      wpl = 24'h000800;
      frame(SFDA_OP_ERASE, 24'h000400, 8'h40, 8'h40, 0, 8'h00);
      post(1'h0, 1'h0, I_AF);
      frame(SFDA_OP_WRITE, 24'h000400, 8'h40, 8'h40, 1, 8'h12);
      post(1'h0, 1'h0, I_AF);
      wpl = 24'h000000;
      rpl = 24'h000800;
      frame(SFDA_OP_READ, 24'h000400, 8'h40, 8'h40, 1, 8'h40);
      post(1'h0, 1'h0, I_AF);
      rpl = 24'h000000;
      frame(SFDA_OP_READ, 24'h000400, 8'h40, 8'h40, 1, 8'hFF);
      post(1'h0, 1'h0, I_NO);
      frame(SFDA_OP_READ, 24'h010000, 8'h40, 8'h40, 1, 8'h40);
      post(1'h0, 1'h0, I_OV);
      frame(SFDA_OP_WRITE, 24'h010000, 8'h40, 8'h40, 1, 8'h77);
      post(1'h0, 1'h0, I_OV);
      conclude();
   end
endmodule : spi_flash_digital_access_bench
`default_nettype wire

// ==== verilog/sfda_mem.sv ====
// byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfda_mem import sfda_pkg::*; #(
   parameter int AW = SFDA_MEM_AW_DEF,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire sfda_mem_req_s req,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] arr [0:(1<<AW)-1];

   // array contents carry no reset, like real flash cells
   always_ff @(posedge clk) begin
      if (req.we) begin
         arr[req.addr[AW-1:0]] <= req.wdata[DW-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (req.re) begin
         rdata <= arr[req.addr[AW-1:0]];
      end
   end
endmodule : sfda_mem
`default_nettype wire

// ==== verilog/sfda_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfda_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sfda_sync
`default_nettype wire

// ==== verilog/sfda_top.sv ====
// serial digital access to the flash array: read, write, sector erase
`timescale 1ns/1ps
`default_nettype none
module sfda_top import sfda_pkg::*; #(
   parameter int MEM_AW = SFDA_MEM_AW_DEF,
   parameter int PROG_TIME_US = SFDA_PROG_TIME_US
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic slave_select_n,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic ready_busy_n,
   input wire logic powered_down_flag,
   input wire logic data_buffer_ready_flag,
   input wire logic channel_busy_flag,
   input wire logic digital_busy_flag,
   input wire logic [SFDA_ADDR_W-1:0] read_protect_limit,
   input wire logic [SFDA_ADDR_W-1:0] write_protect_limit,
   output logic command_busy_flag,
   output logic flash_read_cmd,
   output logic flash_write_cmd,
   output logic address_fault_irq,
   output logic overflow_fault_irq,
   output logic program_done_irq,
   output logic command_done_irq,
   output logic command_reject_irq
);
   localparam int PROG_NS = PROG_TIME_US * SFDA_NS_PER_US;
   localparam int PROG_CYCLES = (PROG_NS + SFDA_CLK_PERIOD_NS - 1) / SFDA_CLK_PERIOD_NS;
   localparam logic [SFDA_PROG_CW-1:0] PROG_LOAD = SFDA_PROG_CW'(PROG_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling and edges

   logic [2:0] pins_s;
   logic sclk_s;
   logic mosi_s;
   logic ssn_s;
   logic sclk_d;
   logic ssn_d;
   logic sel;
   logic rise;
   logic fall;
   logic f_start;
   logic f_end;

   sfda_sync #(.W(3), .RST_VAL(SFDA_PINS_RST)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({spi_sclk, spi_mosi, slave_select_n}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign mosi_s = pins_s[1];
   assign ssn_s = pins_s[0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_d <= 1'h0;
         ssn_d <= 1'h1;
      end else begin
         sclk_d <= sclk_s;
         ssn_d <= ssn_s;
      end
   end

   assign sel = ~ssn_s;
   assign rise = sel & sclk_s & ~sclk_d;
   assign fall = sel & ~sclk_s & sclk_d;
   assign f_start = ssn_d & ~ssn_s;
   assign f_end = ~ssn_d & ssn_s;

   ////////////////////////////////////////////////////////////////////////////
   // byte receive

   logic [2:0] bit_cnt;
   logic [7:0] rx_shift;
   logic [7:0] rx_byte;
   logic byte_done;
   logic first_rise;

   assign rx_byte = {rx_shift[6:0], mosi_s};
   assign byte_done = rise && (bit_cnt == SFDA_BIT_LAST);
   assign first_rise = rise && (bit_cnt == SFDA_BIT_FIRST);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt <= SFDA_BIT_FIRST;
         rx_shift <= SFDA_ZERO;
      end else if (!sel) begin
         bit_cnt <= SFDA_BIT_FIRST;
      end else if (rise) begin
         bit_cnt <= bit_cnt + SFDA_BIT_STEP;
         rx_shift <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command framing

   sfda_phase_e phase;
   sfda_eng_e eng;
   sfda_eng_e next_eng;
   logic [7:0] opcode;
   logic [1:0] addr_cnt;
   logic [SFDA_ADDR_W-1:0] addr;
   logic [SFDA_ADDR_W-1:0] full_addr;
   logic addr_last;
   logic eng_busy;

   assign full_addr = {addr[15:0], rx_byte};
   assign addr_last = byte_done && (phase == PH_ADDR) && (addr_cnt == SFDA_ADDR_LAST);
   assign eng_busy = (eng != ENG_IDLE);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= PH_IDLE;
         opcode <= SFDA_ZERO;
         addr_cnt <= SFDA_ADDR_FIRST;
         addr <= SFDA_ADDR_ZERO;
      end else if (!sel) begin
         phase <= PH_IDLE;
      end else if (f_start) begin
         phase <= PH_OPC;
      end else if (byte_done) begin
         case (phase)
            PH_OPC: begin
               opcode <= rx_byte;
               addr_cnt <= SFDA_ADDR_FIRST;
               if (rx_byte == SFDA_OP_READ || rx_byte == SFDA_OP_WRITE || rx_byte == SFDA_OP_ERASE) begin
                  phase <= PH_ADDR;
               end else begin
                  phase <= PH_SKIP;
               end
            end
            PH_ADDR: begin
               addr <= full_addr;
               addr_cnt <= addr_cnt + 2'h1;
               if (addr_cnt == SFDA_ADDR_LAST) begin
                  if (opcode == SFDA_OP_READ) begin
                     phase <= PH_READ;
                  end else if (opcode == SFDA_OP_WRITE) begin
                     phase <= PH_WRITE;
                  end else begin
                     phase <= PH_SKIP;
                  end
               end
            end
            PH_READ, PH_WRITE: begin
               addr <= addr + SFDA_ADDR_STEP;
            end
            default: begin
               phase <= phase;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status byte and address checks

   sfda_status_s status_now;
   logic [7:0] status_byte;
   logic addr_oor;
   logic addr_rprot;
   logic addr_wprot;
   logic full_oor;
   logic full_wprot;

   always_comb begin
      status_now = '0;
      status_now.dbuf_ready = data_buffer_ready_flag;
      status_now.channel_busy = channel_busy_flag;
      status_now.digital_busy = digital_busy_flag;
      status_now.powered_down = powered_down_flag;
      status_now.command_busy = eng_busy;
   end

   assign status_byte = status_now;
   assign addr_oor = (addr >> MEM_AW) != SFDA_ADDR_ZERO;
   assign addr_rprot = addr < read_protect_limit;
   assign addr_wprot = addr < write_protect_limit;
   assign full_oor = (full_addr >> MEM_AW) != SFDA_ADDR_ZERO;
   assign full_wprot = full_addr < write_protect_limit;

   ////////////////////////////////////////////////////////////////////////////
   // fault and erase decisions

   logic wr_viol;
   logic rd_viol_ev;
   logic wr_byte;
   logic wr_viol_ev;
   logic wr_oor_ev;
   logic wr_prot_ev;
   logic wr_ok;
   logic erase_cmd;
   logic erase_idle;
   logic reject_ev;
   logic eprot_ev;
   logic erase_go;
   logic hold_ok;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_viol <= 1'h0;
      end else if (first_rise) begin
         wr_viol <= ~ready_busy_n;
      end
   end

   assign rd_viol_ev = first_rise && (phase == PH_READ) && !hold_ok;
   assign wr_byte = byte_done && (phase == PH_WRITE);
   assign wr_viol_ev = wr_byte && wr_viol;
   assign wr_oor_ev = wr_byte && !wr_viol && addr_oor;
   assign wr_prot_ev = wr_byte && !wr_viol && !addr_oor && addr_wprot;
   assign wr_ok = wr_byte && !wr_viol && !addr_oor && !addr_wprot && !eng_busy;

   assign erase_cmd = addr_last && (opcode == SFDA_OP_ERASE);
   assign erase_idle = !powered_down_flag && data_buffer_ready_flag && !channel_busy_flag
                       && !digital_busy_flag && !eng_busy;
   assign reject_ev = erase_cmd && !erase_idle;
   assign eprot_ev = erase_cmd && erase_idle && (full_wprot || full_oor);
   assign erase_go = erase_cmd && erase_idle && !full_wprot && !full_oor;

   ////////////////////////////////////////////////////////////////////////////
   // erase and program engine

   logic [SFDA_ADDR_W-1:0] erase_base;
   logic [SFDA_SECTOR_AW-1:0] erase_cnt;
   logic [SFDA_PROG_CW-1:0] prog_cnt;
   logic dirty;
   logic erase_end;
   logic prog_end;

   assign erase_end = (eng == ENG_ERASE) && (erase_cnt == SFDA_SECTOR_LAST);
   assign prog_end = (eng == ENG_PROG) && (prog_cnt == SFDA_PROG_ZERO);

   always_comb begin
      next_eng = eng;
      case (eng)
         ENG_IDLE: begin
            if (erase_go) begin
               next_eng = ENG_ERASE;
            end else if (f_end && dirty) begin
               next_eng = ENG_PROG;
            end
         end
         ENG_ERASE: begin
            if (erase_end) begin
               next_eng = ENG_IDLE;
            end
         end
         ENG_PROG: begin
            if (prog_end) begin
               next_eng = ENG_IDLE;
            end
         end
         default: begin
            next_eng = ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eng <= ENG_IDLE;
         command_busy_flag <= 1'h0;
      end else begin
         eng <= next_eng;
         command_busy_flag <= (next_eng != ENG_IDLE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         erase_base <= SFDA_ADDR_ZERO;
         erase_cnt <= '0;
      end else if (erase_go && !eng_busy) begin
         erase_base <= full_addr;
         erase_cnt <= '0;
      end else if (eng == ENG_ERASE) begin
         erase_cnt <= erase_cnt + SFDA_SECTOR_STEP;
      end
   end

   // stored bytes land at once; the busy window models the cell program time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prog_cnt <= SFDA_PROG_ZERO;
         dirty <= 1'h0;
      end else begin
         if (wr_ok) begin
            dirty <= 1'h1;
         end else if (f_end) begin
            dirty <= 1'h0;
         end
         if (f_end && dirty && !eng_busy && !erase_go) begin
            prog_cnt <= PROG_LOAD;
         end else if (eng == ENG_PROG && !prog_end) begin
            prog_cnt <= prog_cnt - SFDA_PROG_STEP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array access

   sfda_mem_req_s req;
   logic [7:0] rdata;
   logic fetch_pend;
   logic rd_issued;
   logic arr_oor;
   logic arr_rprot;
   logic arrive;
   logic [7:0] arrive_byte;
   logic [7:0] hold;

   // erase owns the array; frame reads wait behind it, frame writes during it are dropped
   always_comb begin
      req = '0;
      if (eng == ENG_ERASE) begin
         req.we = 1'h1;
         req.addr = {erase_base[SFDA_ADDR_W-1:SFDA_SECTOR_AW], erase_cnt};
         req.wdata = SFDA_ERASED;
      end else if (wr_ok) begin
         req.we = 1'h1;
         req.addr = addr;
         req.wdata = rx_byte;
      end else if (fetch_pend && !eng_busy) begin
         req.re = 1'h1;
         req.addr = addr;
      end
   end

   sfda_mem #(.AW(MEM_AW), .DW(8)) u_mem (
      .clk(clk),
      .rst(rst),
      .req(req),
      .rdata(rdata)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_pend <= 1'h0;
         rd_issued <= 1'h0;
         arr_oor <= 1'h0;
         arr_rprot <= 1'h0;
      end else begin
         rd_issued <= req.re && sel;
         if (req.re) begin
            arr_oor <= addr_oor;
            arr_rprot <= addr_rprot;
         end
         if (!sel) begin
            fetch_pend <= 1'h0;
         end else if ((addr_last && opcode == SFDA_OP_READ) || (byte_done && phase == PH_READ)) begin
            fetch_pend <= 1'h1;
         end else if (req.re) begin
            fetch_pend <= 1'h0;
         end
      end
   end

   assign arrive = rd_issued && sel;
   assign arrive_byte = (arr_oor || arr_rprot) ? status_byte : rdata;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold <= SFDA_ZERO;
         hold_ok <= 1'h0;
      end else if (!sel) begin
         hold_ok <= 1'h0;
      end else if ((addr_last && opcode == SFDA_OP_READ) || (byte_done && phase == PH_READ)) begin
         hold <= SFDA_ZERO;
         hold_ok <= 1'h0;
      end else if (byte_done) begin
         hold <= status_byte;
      end else if (arrive) begin
         hold <= arrive_byte;
         hold_ok <= 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // byte transmit, mode 0: load on the falling edge that ends a byte

   logic [7:0] tx_shift;
   logic load_pend;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_shift <= SFDA_ZERO;
         load_pend <= 1'h0;
      end else if (!sel || f_start) begin
         tx_shift <= status_byte;
         load_pend <= 1'h0;
      end else if (fall && load_pend) begin
         tx_shift <= arrive ? arrive_byte : hold;
         load_pend <= 1'h0;
      end else if (fall) begin
         tx_shift <= {tx_shift[6:0], 1'h0};
      end else if (byte_done) begin
         load_pend <= 1'h1;
      end else if (arrive && !rise && !load_pend && bit_cnt == SFDA_BIT_FIRST) begin
         tx_shift <= arrive_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered pins and events

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_miso <= 1'h0;
         spi_miso_oe <= 1'h0;
         ready_busy_n <= 1'h1;
         flash_read_cmd <= 1'h0;
         flash_write_cmd <= 1'h0;
      end else begin
         spi_miso <= sel & tx_shift[7];
         spi_miso_oe <= sel;
         // ready low while busy or fetching
         ready_busy_n <= !eng_busy && !(phase == PH_READ && !hold_ok);
         flash_read_cmd <= (phase == PH_READ);
         flash_write_cmd <= (phase == PH_WRITE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         address_fault_irq <= 1'h0;
         overflow_fault_irq <= 1'h0;
         program_done_irq <= 1'h0;
         command_done_irq <= 1'h0;
         command_reject_irq <= 1'h0;
      end else begin
         address_fault_irq <= (arrive && !arr_oor && arr_rprot) || wr_prot_ev || eprot_ev;
         overflow_fault_irq <= (arrive && arr_oor) || rd_viol_ev || wr_oor_ev || wr_viol_ev;
         program_done_irq <= prog_end;
         command_done_irq <= erase_end;
         command_reject_irq <= reject_ev;
      end
   end
endmodule : sfda_top
`default_nettype wire
